// [rtl/ssram_ctl_pkg.sv]
// constants for the synchronous pipelined memory cycle control block
// assumes a 10 MHz system clock and an ahb-lite master for status access
//
// Contract
// R01: controller waits at least 1 ms after power up before any access.
// R02: burst order is linear when strap is 0, interleaved when 1.
// R03: clock_hold_n low ignores the clock edge; pipeline state is frozen. The code still enters and leaves ST_SLEEP while held.
// R04: no array write happens during a stall cycle.
// R05: controller deselects the device before raising sleep_request.
// R06: data lines stay high impedance when sleep ends.
// R07: while sleep_request is high, device sleeps and keeps memory contents.
// R08: controller holds sleep_request low in normal operation, never floating.
package ssram_ctl_pkg;
    localparam int          CLK_HZ           = 10_000_000;
    localparam int          POWER_WAIT_US    = 1000;      // 1 ms
    localparam int          POWER_WAIT_CYC   = (POWER_WAIT_US * (CLK_HZ / 1_000_000));
    localparam logic [1:0]  BURST_LINEAR     = 2'h0;
    localparam logic        STRAP_LINEAR     = 1'h0;
    localparam logic [31:0] ADDR_STATUS      = 32'h0000_0000;
    localparam logic [31:0] ADDR_CONTROL     = 32'h0000_0004;
    localparam int          STAT_READY_BIT   = 0;
    localparam int          STAT_SLEEP_BIT   = 1;
    localparam int          STAT_MODE_BIT    = 2;
    localparam int          STAT_DRIVE_BIT   = 3;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic        HRESP_OKAY       = 1'h0;
    typedef enum logic [1:0] {ST_POWER, ST_IDLE, ST_READ, ST_SLEEP} pipe_state_t;
endpackage : ssram_ctl_pkg

// [rtl/burst_seq.sv]
// two-bit burst address sequencer, linear or interleaved
// assumes the caller advances it only on a live, non-stalled edge
`timescale 1ns/1ps
module burst_seq
    import ssram_ctl_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_sync_n,
    input  wire logic       load,
    input  wire logic       advance,
    input  wire logic       interleave,
    input  wire logic [1:0] start,
    output logic      [1:0] addr_lsb
);
    logic [1:0] count_r;
    logic [1:0] start_r;

    // counter steps from zero; start kept for both xor and add ordering
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_r <= BURST_LINEAR;
            start_r <= BURST_LINEAR;
        end else if (load) begin
            count_r <= BURST_LINEAR;
            start_r <= start;
        end else if (advance) begin
            count_r <= count_r + 2'h1;
        end
    end

    // interleaved uses xor, linear uses modular add
    assign addr_lsb = interleave ? (start_r ^ count_r) : (start_r + count_r); // R02
endmodule : burst_seq

// [rtl/ssram_ctl.sv]
// cycle control for a synchronous pipelined memory with sleep and stall
// assumes the pins arrive asynchronously and software watches status over ahb-lite
`timescale 1ns/1ps
module ssram_ctl
    import ssram_ctl_pkg::*;
#(
    parameter int AW         = 8,
    parameter int DW         = 18,
    parameter int POWER_WAIT = POWER_WAIT_CYC
)(
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          clock_hold_n,
    input  wire logic          sleep_request,
    input  wire logic          burst_mode,
    input  wire logic          chip_sel_n,
    input  wire logic          write_n,
    input  wire logic          adv_load,
    input  wire logic [AW-1:0] mem_addr,
    input  wire logic [DW-1:0] dq_in,
    output logic      [DW-1:0] dq_out,
    output logic               dq_oe,
    output logic               power_ready,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp
);
    localparam int PW = $clog2(POWER_WAIT + 1);

    logic [1:0]    rst_sync_r;
    logic          rst_sync_n;
    logic [1:0]    hold_s_r, sleep_s_r, mode_s_r, cs_s_r, wr_s_r, adv_s_r;
    logic [AW-1:0] addr_s1_r, addr_s2_r;
    logic [DW-1:0] din_s1_r, din_s2_r;
    logic          live;
    logic [PW-1:0] pwr_cnt_r;
    logic          pwr_ok_r;
    logic          mode_r;
    logic          mode_cap_r;
    pipe_state_t   state_r;
    logic [AW-1:0] base_r;
    logic [1:0]    lsb;
    logic [AW-1:0] cur_addr;
    logic [DW-1:0] mem_r [2**AW];
    logic          wr_en;
    logic          bus_wr_r;
    logic          drive_en_r;
    logic [31:0]   bus_addr_r;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) rst_sync_r <= 2'h0;
        else        rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
    assign rst_sync_n = rst_sync_r[1];

    // two-flop synchronisers for every pin input
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_s_r  <= 2'h3;
            sleep_s_r <= 2'h0;
            mode_s_r  <= 2'h0;
            cs_s_r    <= 2'h3;
            wr_s_r    <= 2'h3;
            adv_s_r   <= 2'h0;
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            din_s1_r  <= '0;
            din_s2_r  <= '0;
        end else if (clk_en) begin
            hold_s_r  <= {hold_s_r[0], clock_hold_n};
            sleep_s_r <= {sleep_s_r[0], sleep_request};
            mode_s_r  <= {mode_s_r[0], burst_mode};
            cs_s_r    <= {cs_s_r[0], chip_sel_n};
            wr_s_r    <= {wr_s_r[0], write_n};
            adv_s_r   <= {adv_s_r[0], adv_load};
            addr_s1_r <= mem_addr;
            addr_s2_r <= addr_s1_r;
            din_s1_r  <= dq_in;
            din_s2_r  <= din_s1_r;
        end
    end

    // an edge counts only when enabled and not held
    assign live = clk_en && hold_s_r[1]; // R03

    // power-up wait before accesses are honoured
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwr_cnt_r <= '0;
            pwr_ok_r  <= 1'h0;
        end else if (clk_en && !pwr_ok_r) begin
            if (pwr_cnt_r == PW'(POWER_WAIT - 1)) pwr_ok_r <= 1'h1; // R01
            pwr_cnt_r <= pwr_cnt_r + PW'(1);
        end
    end

    // burst order strap caught once, when the power wait has ended
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_r     <= STRAP_LINEAR;
            mode_cap_r <= 1'h0;
        end else if (clk_en && !mode_cap_r && pwr_ok_r) begin
            mode_r     <= mode_s_r[1]; // R02
            mode_cap_r <= 1'h1;
        end
    end

    // pipeline state: a stall freezes ST_IDLE and ST_READ except for sleep entry; parked while asleep
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= ST_POWER;
            base_r  <= '0;
        end else if (clk_en) begin
            case (state_r)
                ST_POWER: if (pwr_ok_r) state_r <= ST_IDLE;
                ST_SLEEP: if (!sleep_s_r[1]) state_r <= ST_IDLE; // R06
                default: begin
                    if (sleep_s_r[1] && cs_s_r[1]) begin
                        state_r <= ST_SLEEP; // R07
                    end else if (live) begin // R03
                        if (!cs_s_r[1] && adv_s_r[1]) base_r <= addr_s2_r;
                        if (!cs_s_r[1] && wr_s_r[1]) state_r <= ST_READ;
                        else if (!cs_s_r[1] || adv_s_r[1]) state_r <= ST_IDLE;
                        else state_r <= state_r;
                    end
                end
            endcase
        end
    end

    burst_seq u_burst (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .load       (live && !cs_s_r[1] && adv_s_r[1]),
        .advance    (live && !cs_s_r[1] && !adv_s_r[1]),
        .interleave (mode_r),
        .start      (addr_s2_r[1:0]),
        .addr_lsb   (lsb)
    );
    assign cur_addr = {base_r[AW-1:2], lsb};

    // array write only on a live edge in a powered, awake state
    assign wr_en = live && !cs_s_r[1] && !wr_s_r[1] && !adv_s_r[1]
                   && (state_r == ST_IDLE || state_r == ST_READ); // R04
    always_ff @(posedge clk_sys) begin
        if (wr_en) mem_r[cur_addr] <= din_s2_r; // R07
    end

    // read data and drive enable; dq released in sleep and on wake
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dq_out <= '0;
            dq_oe  <= 1'h0;
        end else if (clk_en) begin
            if (state_r == ST_SLEEP || state_r == ST_POWER || sleep_s_r[1]) begin
                dq_oe <= 1'h0; // R06
            end else if (live) begin
                dq_oe <= (state_r == ST_READ) && drive_en_r;
                if (state_r == ST_READ) dq_out <= mem_r[cur_addr];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) power_ready <= 1'h0;
        else if (clk_en) power_ready <= pwr_ok_r;
    end

    // ahb-lite slave: zero wait states, status and control words
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_wr_r   <= 1'h0;
            bus_addr_r <= '0;
            drive_en_r <= 1'h1;
            hrdata     <= '0;
        end else if (clk_en) begin
            if (bus_wr_r && bus_addr_r == ADDR_CONTROL) drive_en_r <= hwdata[0];
            bus_wr_r <= 1'h0;
            if (hready && hsel && htrans == HTRANS_NONSEQ) begin
                bus_wr_r   <= hwrite;
                bus_addr_r <= haddr;
                hrdata     <= '0;
                if (!hwrite && haddr == ADDR_STATUS) begin
                    hrdata[STAT_READY_BIT] <= pwr_ok_r;
                    hrdata[STAT_SLEEP_BIT] <= (state_r == ST_SLEEP);
                    hrdata[STAT_MODE_BIT]  <= mode_r;
                    hrdata[STAT_DRIVE_BIT] <= dq_oe;
                end else if (!hwrite && haddr == ADDR_CONTROL) begin
                    hrdata[0] <= drive_en_r;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hreadyout <= 1'h1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'h1;
            hresp     <= HRESP_OKAY;
        end
    end

    // power wait holds the pipeline out of service
    a_power_gate: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R01
        !pwr_ok_r |-> state_r == ST_POWER) else $error("access before wait");
    a_power_count: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R01
        $rose(pwr_ok_r) |-> pwr_cnt_r == PW'(POWER_WAIT)) else $error("wait length");
    // a linear burst step moves the low address bits up by one, wrapping
    a_burst_order: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R02
        mode_r == STRAP_LINEAR && live && !cs_s_r[1] && !adv_s_r[1]
        |=> lsb == $past(lsb) + 2'h1) else $error("linear order");
    a_stall_freeze: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R03
        clk_en && !hold_s_r[1] && !sleep_s_r[1] && state_r != ST_POWER
        |=> $stable(state_r) && $stable(base_r)) else $error("stall moved pipe");
    a_stall_nowrite: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R04
        !hold_s_r[1] |-> !wr_en) else $error("write in stall");
    a_sleep_nowrite: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R07
        state_r == ST_SLEEP |-> !wr_en) else $error("write in sleep");
    a_wake_hiz: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R06
        clk_en && state_r == ST_SLEEP && !sleep_s_r[1] |=> !dq_oe)
        else $error("dq driven on wake");
    a_sleep_hiz: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R07
        state_r == ST_SLEEP ##1 state_r == ST_SLEEP |-> !dq_oe)
        else $error("dq driven asleep");
endmodule : ssram_ctl

// [testbench/mem_ctl_model.sv]
// external memory controller model driving the device pins
// assumes the bench calls its tasks; all pins change just after a rising edge
`timescale 1ns/1ps
module mem_ctl_model #(
    parameter int AW = 8,
    parameter int DW = 18
)(
    input  wire logic          clk_sys,
    input  wire logic [DW-1:0] dq_out,
    input  wire logic          dq_oe,
    output logic               clock_hold_n,
    output logic               sleep_request,
    output logic               burst_mode,
    output logic               chip_sel_n,
    output logic               write_n,
    output logic               adv_load,
    output logic      [AW-1:0] mem_addr,
    output logic      [DW-1:0] dq_in
);
    // idle pins: deselected, sleep held low and never left floating
    initial begin
        clock_hold_n  = 1'b1;
        sleep_request = 1'b0;
        burst_mode    = 1'b0;
        chip_sel_n    = 1'b1;
        write_n       = 1'b1;
        adv_load      = 1'b0;
        mem_addr      = '0;
        dq_in         = '0;
    end
    // one cycle of pins; write data toggles when unused so stale data never matches
    task automatic cyc(input logic cs, input logic we, input logic ld, input logic hn,
                       input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        chip_sel_n   <= cs;
        write_n      <= we;
        adv_load     <= ld;
        clock_hold_n <= hn;
        mem_addr     <= a;
        dq_in        <= we ? ~dq_in : d;
    endtask : cyc
    // single read by a load cycle, then a deselect with load high that ends the read,
    // so the data lines drop again and a later read never sees stale data
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v, output bit ok);
        ok = 1'b0;
        v  = '0;
        cyc(1'b0, 1'b1, 1'b1, 1'b1, a, '0);
        cyc(1'b1, 1'b1, 1'b1, 1'b1, '0, '0);
        repeat (12) begin
            @(negedge clk_sys);
            if (!ok && dq_oe === 1'b1) begin
                v  = dq_out;
                ok = 1'b1;
            end
        end
    endtask : rd
    // burst order strap, set while the device is held in reset
    task automatic strap(input logic m);
        @(posedge clk_sys);
        burst_mode <= m;
    endtask : strap
    // sleep request only while deselected
    task automatic sleep(input logic on);
        @(posedge clk_sys);
        chip_sel_n    <= 1'b1;
        sleep_request <= on;
    endtask : sleep
endmodule : mem_ctl_model

// [testbench/ssram_ctl_tb.sv]
// self-checking bench for the memory cycle control block
// assumes the pin partner model and a short power wait
`timescale 1ns/1ps
module ssram_ctl_tb
    import ssram_ctl_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic        clock_hold_n, sleep_request, burst_mode, chip_sel_n, write_n, adv_load;
    logic [7:0]  mem_addr;
    logic [17:0] dq_in, dq_out;
    logic        dq_oe, power_ready, hwrite = 1'b0, hreadyout, hresp;
    logic        hsel = 1'b1, clk_en = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    int          errors, comparisons, cycles;

    ssram_ctl #(.POWER_WAIT(20)) uut (.clk_sys, .rst_n, .clk_en, .clock_hold_n,
        .sleep_request, .burst_mode, .chip_sel_n, .write_n, .adv_load, .mem_addr, .dq_in,
        .dq_out, .dq_oe, .power_ready, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
    mem_ctl_model ctl (.clk_sys, .dq_out, .dq_oe, .clock_hold_n, .sleep_request,
        .burst_mode, .chip_sel_n, .write_n, .adv_load, .mem_addr, .dq_in);

    // clock and hang guard
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one single ahb-lite transfer, waiting on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_sys);
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // reset with a strap value, then the power wait before any access
    task automatic boot(input logic mode);
        ctl.strap(mode);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(negedge clk_sys);
        chk({31'h0, power_ready}, 32'h0);
        repeat (40) @(negedge clk_sys);
        chk({31'h0, power_ready}, 32'h1);
        $display("boot done, mode %0d", mode);
    endtask : boot

    task automatic t_bus();
        logic [31:0] v;
        logic [17:0] d;
        bit          ok;
        ahb(1'b0, ADDR_STATUS, 32'h0, v);
        chk(v, 32'h1);
        ahb(1'b0, ADDR_CONTROL, 32'h0, v);
        chk(v, 32'h1);
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
        // a transfer with the slave unselected must be ignored
        hsel <= 1'b0;
        ahb(1'b1, ADDR_CONTROL, 32'h0, v);
        hsel <= 1'b1;
        ahb(1'b0, ADDR_CONTROL, 32'h0, v);
        chk(v, 32'h1);
        ahb(1'b1, 32'h8, 32'hffff_ffff, v);
        ahb(1'b0, 32'h8, 32'h0, v);
        chk(v, 32'h0);
        ahb(1'b1, ADDR_CONTROL, 32'h0, v);
        ctl.rd(8'h00, d, ok);
        chk({31'h0, ok}, 32'h0);
        ahb(1'b1, ADDR_CONTROL, 32'h1, v);
        $display("bus test done");
    endtask : t_bus

    // write burst from base 1 with a stalled junk write, read back by single loads
    task automatic t_burst(input logic mode);
        logic [31:0] v;
        logic [17:0] d;
        logic [1:0]  a;
        bit          ok;
        ctl.cyc(1'b0, 1'b1, 1'b1, 1'b1, 8'h01, 18'h0);
        for (int k = 1; k <= 4; k++) begin
            if (k == 2) ctl.cyc(1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 18'h3ffff);
            ctl.cyc(1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 18'h0a0 + 18'(k));
        end
        ctl.cyc(1'b1, 1'b1, 1'b0, 1'b1, 8'h00, 18'h0);
        for (int k = 1; k <= 4; k++) begin
            a = mode ? (2'h1 ^ 2'(k - 1)) : (2'h1 + 2'(k - 1));
            ctl.rd({6'h0, a}, d, ok);
            chk({14'h0, d}, 32'h0a0 + 32'(k));
        end
        ahb(1'b0, ADDR_STATUS, 32'h0, v);
        chk(v, {29'h0, mode, 2'h1});
        $display("burst test done, mode %0d", mode);
    endtask : t_burst

    // sleep while deselected, then data lines stay released and contents kept
    task automatic t_sleep();
        logic [31:0] v;
        logic [17:0] d;
        bit          ok;
        ctl.sleep(1'b1);
        repeat (6) @(posedge clk_sys);
        ahb(1'b0, ADDR_STATUS, 32'h0, v);
        chk(v, 32'h3);
        ctl.sleep(1'b0);
        repeat (8) begin
            @(negedge clk_sys);
            chk({31'h0, dq_oe}, 32'h0);
        end
        repeat (4) @(posedge clk_sys);
        ctl.rd(8'h01, d, ok);
        chk({14'h0, d}, 32'h0a1);
        $display("sleep test done");
    endtask : t_sleep

    // clock enable low freezes the pipeline, so a read cannot complete
    task automatic t_freeze();
        logic [17:0] d;
        bit          ok;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        ctl.rd(8'h01, d, ok);
        chk({31'h0, ok}, 32'h0);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ctl.rd(8'h01, d, ok);
        chk({14'h0, d}, 32'h0a1);
        $display("freeze test done");
    endtask : t_freeze

    task automatic results();
        $display("comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // main sequence
    initial begin
        boot(1'b0);
        t_bus();
        t_burst(1'b0);
        t_sleep();
        t_freeze();
        boot(1'b1);
        t_burst(1'b1);
        results();
    end
endmodule : ssram_ctl_tb
